// *** verilog/spsc_pkg.sv ***
// shared constants for the standby pin-state control block
package spsc_pkg;

   // ----------------------------------------------------------------
   // pin count and synchroniser depth
   // ----------------------------------------------------------------
   localparam int NUM_PINS = 8;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // power modes from the power-mode controller
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPSC_MODE_RUN   = 2'h0,
      SPSC_MODE_SLEEP = 2'h1,
      SPSC_MODE_STOP  = 2'h2,
      SPSC_MODE_WATCH = 2'h3
   } spsc_mode_t;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [NUM_PINS-1:0] DIR_RESET  = 8'h00;
   localparam logic [NUM_PINS-1:0] HOLD_RESET = 8'h00;
   localparam logic                STBY_RESET = 1'h0;

endpackage : spsc_pkg

// *** verilog/spsc_sync.sv ***
// two-flop synchroniser for a bus of pin levels
module spsc_sync
   import spsc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             resetn_in,
   // async levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
      end
   end

   assign sync_out = stage2;

endmodule : spsc_sync

// *** verilog/spsc_top.sv ***
// pin-state control for general-purpose pins across run, sleep, stop and watch modes
module spsc_top
   import spsc_pkg::*;
(
   // clock and reset
   input  wire logic                sys_clk_in,
   input  wire logic                resetn_in,
   // power mode and standby select
   input  wire spsc_mode_t          power_mode_in,
   input  wire logic                standby_pin_hiz_select_in,
   // per-pin configuration
   input  wire logic [NUM_PINS-1:0] port_direction_wr_in,
   input  wire logic [NUM_PINS-1:0] port_direction_data_in,
   input  wire logic [NUM_PINS-1:0] port_out_data_in,
   input  wire logic [NUM_PINS-1:0] pullup_enable_in,
   input  wire logic [NUM_PINS-1:0] analog_shared_in,
   input  wire logic [NUM_PINS-1:0] ext_irq_shared_in,
   input  wire logic [NUM_PINS-1:0] ext_irq_enable_in,
   // pad side
   input  wire logic [NUM_PINS-1:0] pad_level_in,
   output logic      [NUM_PINS-1:0] pad_data_out,
   output logic      [NUM_PINS-1:0] pad_oe_out,
   output logic      [NUM_PINS-1:0] pad_pullup_out,
   // core side
   output logic      [NUM_PINS-1:0] port_direction_out,
   output logic      [NUM_PINS-1:0] port_in_out,
   output logic      [NUM_PINS-1:0] ext_irq_in_out,
   output logic                     standby_active_out
);

   // ----------------------------------------------------------------
   // pad input synchroniser
   // ----------------------------------------------------------------
   logic [NUM_PINS-1:0] pad_sync;

   spsc_sync #(
      .WIDTH(NUM_PINS)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .async_in   (pad_level_in),
      .sync_out   (pad_sync)
   );

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   function automatic logic is_standby(input spsc_mode_t m);
      return (m == SPSC_MODE_STOP) || (m == SPSC_MODE_WATCH);
   endfunction : is_standby

   // ----------------------------------------------------------------
   // state: direction, standby flag, held drive, hi-z select latch
   // ----------------------------------------------------------------
   logic [NUM_PINS-1:0] direction;
   logic [NUM_PINS-1:0] next_direction;
   logic [NUM_PINS-1:0] hold_data;
   logic [NUM_PINS-1:0] next_hold_data;
   logic [NUM_PINS-1:0] hold_oe;
   logic [NUM_PINS-1:0] next_hold_oe;
   logic                stby;
   logic                next_stby;
   logic                hiz_sel;
   logic                next_hiz_sel;
   logic                entering;

   always_comb begin
      entering       = is_standby(power_mode_in) && !stby;
      next_stby      = is_standby(power_mode_in);
      next_hold_data = hold_data;
      next_hold_oe   = hold_oe;
      next_hiz_sel   = hiz_sel;
      next_direction = direction;
      if (!stby) begin
         next_direction = (direction & ~port_direction_wr_in)
                        | (port_direction_data_in & port_direction_wr_in);
      end
      if (entering) begin
         // capture drive state at entry
         next_hold_data = port_out_data_in;
         next_hold_oe   = direction;
         next_hiz_sel   = standby_pin_hiz_select_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         direction <= DIR_RESET;
         hold_data <= HOLD_RESET;
         hold_oe   <= HOLD_RESET;
         stby      <= STBY_RESET;
         hiz_sel   <= STBY_RESET;
      end else begin
         direction <= next_direction;
         hold_data <= next_hold_data;
         hold_oe   <= next_hold_oe;
         stby      <= next_stby;
         hiz_sel   <= next_hiz_sel;
      end
   end

   // ----------------------------------------------------------------
   // pad drive and input gating, registered
   // ----------------------------------------------------------------
   logic [NUM_PINS-1:0] next_pad_data;
   logic [NUM_PINS-1:0] next_pad_oe;
   logic [NUM_PINS-1:0] next_pad_pullup;
   logic [NUM_PINS-1:0] next_port_in;
   logic [NUM_PINS-1:0] next_ext_irq;
   logic [NUM_PINS-1:0] gate_open;
   logic                analog_reset_blk;
   logic [NUM_PINS-1:0] pad_data;
   logic [NUM_PINS-1:0] pad_oe;
   logic [NUM_PINS-1:0] pad_pullup;
   logic [NUM_PINS-1:0] port_in;
   logic [NUM_PINS-1:0] ext_irq;
   logic                post_reset;

   always_comb begin
      // analog-shared pins stay blocked until first edge after release
      analog_reset_blk = !post_reset;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (stby && hiz_sel) begin
            next_pad_oe[i]     = 1'b0;
            next_pad_data[i]   = 1'b0;
            next_pad_pullup[i] = pullup_enable_in[i];
            gate_open[i]       = 1'b0;
         end else if (stby) begin
            next_pad_oe[i]     = hold_oe[i];
            next_pad_data[i]   = hold_data[i];
            next_pad_pullup[i] = pullup_enable_in[i] && !(hold_oe[i] && !hold_data[i]);
            gate_open[i]       = 1'b0;
         end else begin
            // run/sleep or after wake: current configuration
            next_pad_oe[i]     = direction[i];
            next_pad_data[i]   = port_out_data_in[i];
            next_pad_pullup[i] = pullup_enable_in[i] && !(direction[i] && !port_out_data_in[i]);
            gate_open[i]       = !(analog_shared_in[i] && analog_reset_blk);
         end
         next_port_in[i] = gate_open[i] & pad_sync[i];
         next_ext_irq[i] = ext_irq_shared_in[i]
                         & (gate_open[i] | (stby & ext_irq_enable_in[i]))
                         & pad_sync[i];
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         // floating, input function off in effect
         pad_data   <= '0;
         pad_oe     <= '0;
         pad_pullup <= '0;
         port_in    <= '0;
         ext_irq    <= '0;
         post_reset <= 1'b0;
      end else begin
         pad_data   <= next_pad_data;
         pad_oe     <= next_pad_oe;
         pad_pullup <= next_pad_pullup;
         port_in    <= next_port_in;
         ext_irq    <= next_ext_irq;
         post_reset <= 1'b1;
      end
   end

   assign pad_data_out       = pad_data;
   assign pad_oe_out         = pad_oe;
   assign pad_pullup_out     = pad_pullup;
   assign port_in_out        = port_in;
   assign ext_irq_in_out     = ext_irq;
   assign port_direction_out = direction;
   assign standby_active_out = stby;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   a_run_follows_cfg: assert property (
      !stby ##1 !stby |-> pad_oe == $past(direction))
      else $error("run mode drive differs from direction");
   a_hold_state: assert property (
      stby && !hiz_sel ##1 stby |-> pad_data == $past(hold_data) && pad_oe == $past(hold_oe))
      else $error("held state not kept in standby");
   a_hiz_forced: assert property (
      stby && hiz_sel |=> pad_oe == '0)
      else $error("pin driven while hi-z selected");
   a_pullup_kept: assert property (
      stby && hiz_sel |=> pad_pullup == $past(pullup_enable_in))
      else $error("pull-up lost in hi-z standby");
   a_irq_live: assert property (
      stby |=> ext_irq == ($past(ext_irq_shared_in & ext_irq_enable_in & pad_sync)))
      else $error("interrupt path wrong in standby");
   a_input_blocked: assert property (
      stby |=> port_in == '0)
      else $error("input reached port while blocked");
   a_wake_restore: assert property (
      $fell(stby) |=> pad_oe == $past(direction, 1))
      else $error("no return to configuration after wake");
   a_dir_hold: assert property (
      stby |=> direction == $past(direction))
      else $error("direction changed in standby");

   c_stop_hiz:   cover property (power_mode_in == SPSC_MODE_STOP && standby_pin_hiz_select_in ##1 stby);
   c_watch_hold: cover property (power_mode_in == SPSC_MODE_WATCH && !standby_pin_hiz_select_in ##1 stby);
   c_wake:       cover property ($fell(stby));
   c_irq_wake:   cover property (stby && |ext_irq);

endmodule : spsc_top

// *** verif/spsc_pad_model.sv ***
// board model that resolves each pin level
module spsc_pad_model
   import spsc_pkg::*;
(
   // pad side of the design
   input  wire logic                sys_clk_in,
   input  wire logic [NUM_PINS-1:0] pad_data_in,
   input  wire logic [NUM_PINS-1:0] pad_oe_in,
   input  wire logic [NUM_PINS-1:0] pad_pullup_in,
   // outside drivers
   input  wire logic [NUM_PINS-1:0] ext_en_in,
   input  wire logic [NUM_PINS-1:0] ext_level_in,
   output logic      [NUM_PINS-1:0] pad_level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NUM_PINS-1:0] wander = 8'h55;
   always @(posedge sys_clk_in) wander <= ~wander;
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (pad_oe_in[i]) pad_level_out[i] = pad_data_in[i];
         else if (ext_en_in[i]) pad_level_out[i] = ext_level_in[i];
         else if (pad_pullup_in[i]) pad_level_out[i] = 1'b1;
         else pad_level_out[i] = wander[i];
      end
   end
endmodule : spsc_pad_model

// *** verif/spsc_top_tb_top.sv ***
// self-checking bench for the pin-state control block
module spsc_top_tb_top;
   import spsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0, resetn_in = 1'b0, sel = 1'b0;
   spsc_mode_t mode = SPSC_MODE_RUN;
   logic [NUM_PINS-1:0] wr = 8'h00, dir = 8'h00, odat = 8'hA5, pu = 8'hFF, ext = 8'h3C, lvl;
   logic [NUM_PINS-1:0] d_o, oe_o, pu_o, dir_o, in_o, irq_o;
   logic stby_o;
   int miscompares = 0, checks = 0, cycles = 0;
   spsc_top dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .power_mode_in(mode),
      .standby_pin_hiz_select_in(sel), .port_direction_wr_in(wr), .port_direction_data_in(dir),
      .port_out_data_in(odat), .pullup_enable_in(pu), .analog_shared_in(8'h03),
      .ext_irq_shared_in(8'h0F), .ext_irq_enable_in(8'h05), .pad_level_in(lvl), .pad_data_out(d_o),
      .pad_oe_out(oe_o), .pad_pullup_out(pu_o), .port_direction_out(dir_o), .port_in_out(in_o),
      .ext_irq_in_out(irq_o), .standby_active_out(stby_o));
   spsc_pad_model board (.sys_clk_in(sys_clk_in), .pad_data_in(d_o), .pad_oe_in(oe_o),
      .pad_pullup_in(pu_o), .ext_en_in(8'h3F), .ext_level_in(ext), .pad_level_out(lvl));
   initial begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   task automatic chk(input logic [NUM_PINS-1:0] got, input logic [NUM_PINS-1:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : wait_cyc
   task automatic complete_run;
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         complete_run();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset;
      resetn_in = 1'b0;
      wait_cyc(3);
      chk(oe_o, 8'h00);
      chk(pu_o | d_o, 8'h00);
      chk(dir_o, 8'h00);
      chk(in_o & 8'h03, 8'h00);
      resetn_in = 1'b1;
      wait_cyc(1);
   endtask : test_reset
   task automatic test_active(input spsc_mode_t m);
      mode = m;
      wr = 8'hFF;
      dir = 8'h0F;
      wait_cyc(1);
      wr = 8'h00;
      wait_cyc(4);
      chk(dir_o, 8'h0F);
      chk(oe_o, 8'h0F);
      chk(d_o & oe_o, 8'h05);
      chk(pu_o, 8'hF5);
      chk(in_o, 8'hF5);
      chk({7'h00, stby_o}, 8'h00);
   endtask : test_active
   task automatic test_standby(input spsc_mode_t m, input logic s);
      sel = s;
      mode = m;
      wait_cyc(1);
      sel = ~s;
      wr = 8'hFF;
      dir = 8'hF0;
      odat = 8'h5A;
      ext = 8'hC3;
      wait_cyc(1);
      wr = 8'h00;
      wait_cyc(3);
      chk({7'h00, stby_o}, 8'h01);
      chk(dir_o, 8'h0F);
      chk(oe_o, s ? 8'h00 : 8'h0F);
      chk(d_o & oe_o, s ? 8'h00 : 8'h05);
      chk(pu_o, s ? 8'hFF : 8'hF5);
      chk(in_o, 8'h00);
      chk(irq_o, s ? 8'h01 : 8'h05);
      mode = SPSC_MODE_RUN;
      // pads restore two edges on, then two sync flops and the input register
      wait_cyc(5);
      chk({7'h00, stby_o}, 8'h00);
      chk(oe_o, 8'h0F);
      chk(in_o, 8'hCA);
      odat = 8'hA5;
      ext = 8'h3C;
      wait_cyc(1);
   endtask : test_standby
   initial begin
      test_reset();
      test_active(SPSC_MODE_RUN);
      test_active(SPSC_MODE_SLEEP);
      test_standby(SPSC_MODE_STOP, 1'b0);
      test_standby(SPSC_MODE_STOP, 1'b1);
      test_standby(SPSC_MODE_WATCH, 1'b0);
      test_standby(SPSC_MODE_WATCH, 1'b1);
      test_reset();
      complete_run();
   end
endmodule : spsc_top_tb_top
